//--- design/pcmr_pkg.sv
// pcmr_pkg: register map, status bit positions and codes of the
// particle counter holding-register bank. assumes 16-bit registers.
package pcmr_pkg;
	localparam logic [15:0] ADDR_STATUS = 16'h0006;
	localparam logic [15:0] ADDR_CH1 = 16'h0008;
	localparam logic [15:0] ADDR_CH2 = 16'h000A;
	localparam logic [15:0] ADDR_CH3 = 16'h000C;
	localparam logic [15:0] ADDR_CH4 = 16'h000E;
	localparam logic [15:0] ADDR_UNIT = 16'h006E;
	localparam logic [15:0] ADDR_ALO = 16'h007C;
	localparam logic [15:0] ADDR_AHI = 16'h007E;
	localparam logic [15:0] ADDR_AROUTE = 16'h0080;
	localparam logic [15:0] ADDR_ALIMIT = 16'h0082;
	localparam logic [15:0] ADDR_AMROUTE = 16'h0084;
	localparam int ST_LASER = 0;
	localparam int ST_FLOW = 1;
	localparam int ST_OVFL = 2;
	localparam int ST_SERVICE = 3;
	localparam int ST_THRESH = 4;
	localparam int ST_ALARM = 5;
	localparam logic [7:0] FC_READ_HOLD = 8'h03;
	localparam logic [7:0] FC_EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
	localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
	typedef enum logic [1:0] {
		PCMR_IDLE = 2'b00,
		PCMR_LOOK = 2'b01,
		PCMR_SEND = 2'b11
	} pcmr_state_t;
endpackage

//--- design/pcmr_regs.sv
// pcmr_regs: read-only holding-register bank of a particle counter,
// status flags and alarm relay. assumes a framer upstream that hands
// over decoded read requests (function, start, quantity) and takes one
// response word at a time.
`timescale 1ns/1ps
// Overview of operation
// R1 - status word at 6, four float count channels at 8 to 14, read only
// R2 - scaling at 124/126, analog routing 128, threshold 130, routing 132
// R3 - eight-byte unit string at 110; missing channel returns null string
// R4 - answers carry function code 03; master reads with function 03
// R5 - 32-bit values go out mid-little-endian, low word first
// R6 - master reorders received bytes into its own endianness
// R7 - status word is independent single-bit flags, unused bits zero
// R8 - bit 0 is laser alert
// R9 - bit 1 is flow rate alert
// R10 - bit 2 is particle overflow or malfunction
// R11 - bit 3 is service threshold exceeded
// R12 - bit 4 is particle count threshold exceeded
// R13 - bit 5 is alarm triggered
// R14 - relay closed while powered and count below threshold
// R15 - relay opens once count reaches threshold, open when unpowered
// R16 - relay switches only when enabled, compares selected channel only
// R17 - unmapped address gets an exception response, not data
// R18 - status bit 5 and relay change in the same cycle
module pcmr_regs
	import pcmr_pkg::*;
(
	input wire logic clk, // 10 MHz clock
	input wire logic srst, // sync reset, active high
	input wire logic req_valid, // read request strobe
	input wire logic [7:0] req_func, // request function code
	input wire logic [15:0] req_start, // first register address
	input wire logic [7:0] req_qty, // number of registers
	output logic req_ready, // bank idle, request accepted
	output logic rsp_valid, // response word valid
	input wire logic rsp_ready, // framer takes word
	output logic [7:0] rsp_func, // response function code
	output logic [15:0] rsp_data, // register word or exception code
	output logic rsp_exc, // response is an exception
	output logic rsp_last, // final word of response
	input wire logic laser_alert, // laser condition
	input wire logic flow_alert, // flow condition
	input wire logic overflow_alert, // overflow or malfunction
	input wire logic service_alert, // service threshold exceeded
	input wire logic thresh_alert, // particle threshold exceeded
	input wire logic cnt_update, // new counts present, one cycle
	input wire logic [127:0] counts, // four float channels, ch1 low
	input wire logic [63:0] unit_str, // unit ascii string
	input wire logic [3:0] ch_present, // channel exists in model
	input wire logic [31:0] alo, // 4 mA scale float
	input wire logic [31:0] ahi, // 20 mA scale float
	input wire logic [15:0] aroute, // analog routing
	input wire logic [31:0] alimit, // alarm threshold float
	input wire logic [31:0] amroute, // alarm routing, channel 0..3
	input wire logic alarm_en, // alarm enabled
	output logic relay_closed // relay contact closed
);
	pcmr_state_t state_reg, state_next;
	logic [15:0] addr_reg;
	logic [7:0] left_reg;
	logic exc_reg;
	logic [7:0] exc_code_reg;
	logic alarm_reg;
	logic [4:0] flags_reg;
	logic [7:0] func_reg;
	logic [15:0] data_reg;
	logic last_reg;

	pcmr_word_if wp();

	wire [1:0] mon_sel = amroute[1:0];
	wire [31:0] mon_cnt = counts[32*mon_sel +: 32];
	// positive floats order like unsigned integers; a negative count
	// cannot occur, so no float comparator is spent here
	wire reached = mon_cnt >= alimit;
	wire [31:0] status_word = {26'h0, alarm_reg, flags_reg}; // R7
	wire bad_func = req_func != FC_READ_HOLD; // R4
	wire bad_qty = req_qty == 8'h00;

	// unit string is empty when the monitored channel is absent
	wire [63:0] unit_eff = ch_present[mon_sel] ? unit_str : 64'h0; // R3

	assign wp.addr = addr_reg;

	pcmr_word_map u_map (
		.wp(wp),
		.status(status_word),
		.counts(counts),
		.unit_str(unit_eff),
		.alo(alo),
		.ahi(ahi),
		.aroute(aroute),
		.alimit(alimit),
		.amroute(amroute)
	);

	assign req_ready = state_reg == PCMR_IDLE;
	assign rsp_valid = state_reg == PCMR_SEND;
	assign rsp_func = func_reg;
	assign rsp_data = data_reg;
	assign rsp_exc = exc_reg;
	assign rsp_last = last_reg;
	// reset closes the contact at the next clock edge, disabled closes it at the next
	// count update; power loss opens it mechanically
	assign relay_closed = !alarm_reg; // R14 R15 R18

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			PCMR_IDLE: if (req_valid) state_next = PCMR_LOOK;
			PCMR_LOOK: state_next = PCMR_SEND;
			PCMR_SEND: begin
				if (rsp_ready)
					state_next = last_reg ? PCMR_IDLE : PCMR_LOOK;
			end
			default: state_next = PCMR_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) state_reg <= PCMR_IDLE;
		else state_reg <= state_next;
	end

	// request capture; function and quantity faults are refused up
	// front, an unmapped address aborts the answer where it is met
	always_ff @(posedge clk) begin
		if (srst) begin
			addr_reg <= 16'h0000;
			left_reg <= 8'h00;
			exc_reg <= 1'b0;
			exc_code_reg <= 8'h00;
			func_reg <= 8'h00;
		end else if (state_reg == PCMR_IDLE && req_valid) begin
			addr_reg <= req_start;
			left_reg <= req_qty;
			exc_reg <= bad_func || bad_qty;
			exc_code_reg <= bad_func ? EXC_BAD_FUNC : EXC_BAD_ADDR;
			func_reg <= (bad_func || bad_qty) ? (req_func | FC_EXC_FLAG)
				: FC_READ_HOLD; // R4 R17
		end else if (state_reg == PCMR_LOOK && !exc_reg && !wp.hit) begin
			exc_reg <= 1'b1; // R17
			exc_code_reg <= EXC_BAD_ADDR;
			func_reg <= FC_READ_HOLD | FC_EXC_FLAG;
		end else if (state_reg == PCMR_SEND && rsp_ready) begin
			addr_reg <= addr_reg + 16'h0001;
			left_reg <= left_reg - 8'h01;
		end
	end

	// an unmapped address anywhere in the range aborts with exception
	wire look_exc = exc_reg || !wp.hit;

	always_ff @(posedge clk) begin
		if (srst) begin
			data_reg <= 16'h0000;
			last_reg <= 1'b0;
		end else if (state_reg == PCMR_LOOK) begin
			data_reg <= look_exc ? {8'h00, (exc_reg ? exc_code_reg
				: EXC_BAD_ADDR)} : wp.data; // R1 R2 R5 R17
			last_reg <= look_exc || left_reg == 8'h01;
		end
	end

	// flags refresh with each count update
	always_ff @(posedge clk) begin
		if (srst) begin
			flags_reg <= 5'h00;
			alarm_reg <= 1'b0;
		end else if (cnt_update) begin
			flags_reg[ST_LASER] <= laser_alert; // R8
			flags_reg[ST_FLOW] <= flow_alert; // R9
			flags_reg[ST_OVFL] <= overflow_alert; // R10
			flags_reg[ST_SERVICE] <= service_alert; // R11
			flags_reg[ST_THRESH] <= thresh_alert; // R12
			alarm_reg <= alarm_en && reached; // R13 R15 R16 R18
		end
	end

	property p_relay_follows;
		@(posedge clk) disable iff (srst)
		cnt_update |=> (relay_closed == !($past(alarm_en)
			&& $past(mon_cnt) >= $past(alimit)));
	endproperty
	AST_RELAY_TRACK: assert property (p_relay_follows) // R15
		else $error("relay does not follow threshold");
	AST_RELAY_DISABLED: assert property (@(posedge clk) // R16
		disable iff (srst) cnt_update && !alarm_en |=> relay_closed)
		else $error("relay opened while alarm disabled");
	AST_RELAY_BELOW: assert property (@(posedge clk) // R14
		disable iff (srst) cnt_update && mon_cnt < alimit |=> relay_closed)
		else $error("relay open below threshold");
	AST_ALARM_BIT: assert property (@(posedge clk) // R18
		disable iff (srst) cnt_update && alarm_en && reached
			|=> status_word[ST_ALARM] && !relay_closed)
		else $error("alarm bit and relay disagree");
	AST_UNUSED_ZERO: assert property (@(posedge clk) // R7
		disable iff (srst) state_reg == PCMR_LOOK && !exc_reg
			&& addr_reg == ADDR_STATUS + 16'h0001
			|=> rsp_data[15:6] == 10'h000)
		else $error("unused status bits set");
	AST_LASER_BIT: assert property (@(posedge clk) // R8
		disable iff (srst)
		cnt_update |=> status_word[ST_LASER] == $past(laser_alert))
		else $error("laser bit wrong");
	AST_FLOW_BIT: assert property (@(posedge clk) // R9
		disable iff (srst)
		cnt_update |=> status_word[ST_FLOW] == $past(flow_alert))
		else $error("flow bit wrong");
	AST_OVFL_BIT: assert property (@(posedge clk) // R10
		disable iff (srst)
		cnt_update |=> status_word[ST_OVFL] == $past(overflow_alert))
		else $error("overflow bit wrong");
	AST_SERVICE_BIT: assert property (@(posedge clk) // R11
		disable iff (srst)
		cnt_update |=> status_word[ST_SERVICE] == $past(service_alert))
		else $error("service bit wrong");
	AST_THRESH_BIT: assert property (@(posedge clk) // R12
		disable iff (srst)
		cnt_update |=> status_word[ST_THRESH] == $past(thresh_alert))
		else $error("threshold bit wrong");
	sequence s_read_start;
		state_reg == PCMR_IDLE && req_valid && req_func == FC_READ_HOLD
			&& req_start == ADDR_STATUS && req_qty != 8'h00;
	endsequence
	sequence s_status_word;
		##2 rsp_valid && !rsp_exc && rsp_data == status_word[15:0];
	endsequence
	AST_STATUS_LOW_FIRST: assert property (@(posedge clk) // R5
		disable iff (srst) s_read_start |-> s_status_word)
		else $error("status low word not sent first");
	AST_FUNC_CODE: assert property (@(posedge clk) // R4
		disable iff (srst)
		rsp_valid && !rsp_exc |-> rsp_func == FC_READ_HOLD)
		else $error("wrong function code");
	AST_EXC_FUNC: assert property (@(posedge clk) // R17
		disable iff (srst) rsp_valid && rsp_exc |-> rsp_func[7])
		else $error("exception without exception function code");
	AST_EXC_UNMAPPED: assert property (@(posedge clk) // R17
		disable iff (srst) state_reg == PCMR_LOOK && !wp.hit
			|=> rsp_valid && rsp_exc && rsp_last)
		else $error("unmapped address not refused");
	AST_CH1_READ: assert property (@(posedge clk) // R1
		disable iff (srst)
		state_reg == PCMR_LOOK && addr_reg == ADDR_CH1 && !exc_reg
			|=> rsp_data == $past(counts[15:0]))
		else $error("channel one low word wrong");
	AST_LIMIT_READ: assert property (@(posedge clk) // R2
		disable iff (srst)
		state_reg == PCMR_LOOK && addr_reg == ADDR_ALIMIT + 16'h0001
			&& !exc_reg |=> rsp_data == $past(alimit[31:16]))
		else $error("threshold high word wrong");
	AST_UNIT_NULL: assert property (@(posedge clk) // R3
		disable iff (srst)
		state_reg == PCMR_LOOK && addr_reg == ADDR_UNIT && !exc_reg
			&& !ch_present[mon_sel] |=> rsp_data == 16'h0000)
		else $error("absent channel unit not null");
endmodule

//--- design/pcmr_word_if.sv
// pcmr_word_if: one register lookup between the bank and its decoder.
// assumes both ends on the same clock.
`timescale 1ns/1ps
interface pcmr_word_if;
	logic [15:0] addr; // register address
	logic [15:0] data; // register content
	logic hit; // address is mapped
	modport bank (input addr, output data, output hit);
	modport user (output addr, input data, input hit);
endinterface

//--- design/pcmr_word_map.sv
// pcmr_word_map: combinational register decode of the bank.
// maps 32-bit values low word first on the wire.
`timescale 1ns/1ps
module pcmr_word_map
	import pcmr_pkg::*;
(
	pcmr_word_if.bank wp, // lookup port
	input wire logic [31:0] status, // status word
	input wire logic [127:0] counts, // four float channels
	input wire logic [63:0] unit_str, // unit ascii string
	input wire logic [31:0] alo, // 4 mA scale
	input wire logic [31:0] ahi, // 20 mA scale
	input wire logic [15:0] aroute, // analog routing
	input wire logic [31:0] alimit, // alarm threshold
	input wire logic [31:0] amroute // alarm routing
);
	wire [15:0] a = wp.addr;
	wire [15:0] ch_hi[4];
	wire [15:0] ch_lo[4];
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_ch
			assign ch_hi[g] = counts[32*g+16 +: 16];
			assign ch_lo[g] = counts[32*g +: 16];
		end
	endgenerate
	// mid-little-endian: bytes ABCD of a big-endian value go out as
	// CDAB, so the low word is sent first R5
	always_comb begin
		wp.hit = 1'b1;
		unique case (a)
			ADDR_STATUS: wp.data = status[15:0]; // R1 R5
			ADDR_STATUS + 16'h0001: wp.data = status[31:16];
			ADDR_CH1: wp.data = ch_lo[0]; // R1
			ADDR_CH1 + 16'h0001: wp.data = ch_hi[0];
			ADDR_CH2: wp.data = ch_lo[1];
			ADDR_CH2 + 16'h0001: wp.data = ch_hi[1];
			ADDR_CH3: wp.data = ch_lo[2];
			ADDR_CH3 + 16'h0001: wp.data = ch_hi[2];
			ADDR_CH4: wp.data = ch_lo[3];
			ADDR_CH4 + 16'h0001: wp.data = ch_hi[3];
			ADDR_UNIT: wp.data = unit_str[63:48]; // R3
			ADDR_UNIT + 16'h0001: wp.data = unit_str[47:32];
			ADDR_UNIT + 16'h0002: wp.data = unit_str[31:16];
			ADDR_UNIT + 16'h0003: wp.data = unit_str[15:0];
			ADDR_ALO: wp.data = alo[15:0]; // R2
			ADDR_ALO + 16'h0001: wp.data = alo[31:16];
			ADDR_AHI: wp.data = ahi[15:0];
			ADDR_AHI + 16'h0001: wp.data = ahi[31:16];
			ADDR_AROUTE: wp.data = aroute;
			ADDR_ALIMIT: wp.data = alimit[15:0];
			ADDR_ALIMIT + 16'h0001: wp.data = alimit[31:16];
			ADDR_AMROUTE: wp.data = amroute[15:0];
			ADDR_AMROUTE + 16'h0001: wp.data = amroute[31:16];
			default: begin
				wp.hit = 1'b0; // R17
				wp.data = 16'h0000;
			end
		endcase
	end
endmodule

//--- tb/pcmr_mstr.sv
// pcmr_mstr: behavioural bus master polling the register bank.
// assumes the bank clock on clk; drives on the falling edge.
`timescale 1ns/1ps
module pcmr_mstr (
	input wire logic clk, // bank clock
	output logic req_valid, // read request
	output logic [7:0] req_func, // function code
	output logic [15:0] req_start, // first address
	output logic [7:0] req_qty, // register count
	input wire logic req_ready, // bank idle
	input wire logic rsp_valid, // word offered
	output logic rsp_ready, // word taken
	input wire logic [7:0] rsp_func, // answer function code
	input wire logic [15:0] rsp_data, // answer word
	input wire logic rsp_exc, // exception word
	input wire logic rsp_last // final word
);
	logic [15:0] words[$];
	logic [7:0] last_func;
	logic last_exc;
	int stall = 0;
	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_start = 16'h0000;
		req_qty = 8'h00;
		rsp_ready = 1'b0;
	end
	// low word comes first on the wire; rebuild high word first
	function automatic logic [31:0] w32(input int i);
		return {words[i + 1], words[i]};
	endfunction
	task automatic read(input logic [7:0] f, input logic [15:0] a,
		input logic [7:0] q);
		int n;
		logic done;
		words.delete();
		@(negedge clk);
		req_valid = 1'b1;
		req_func = f;
		req_start = a;
		req_qty = q;
		n = 0;
		while (req_ready !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		// scrambled after release so nothing leans on stale fields
		req_valid = 1'b0;
		req_func = ~f;
		req_start = ~a;
		req_qty = ~q;
		done = 1'b0;
		n = 0;
		while (!done && n < 300) begin
			rsp_ready = (n % (stall + 1)) == stall;
			if (rsp_valid === 1'b1 && rsp_ready) begin
				words.push_back(rsp_data);
				last_func = rsp_func;
				last_exc = rsp_exc;
				done = rsp_last;
			end
			@(negedge clk);
			n++;
		end
		rsp_ready = 1'b0;
	endtask
endmodule

//--- tb/tb.sv
// tb: self-checking bench of the holding-register bank.
// assumes pcmr_mstr on the request and response side.
`timescale 1ns/1ps
module tb
	import pcmr_pkg::*;
;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic req_valid, req_ready, rsp_valid, rsp_ready, rsp_exc, rsp_last;
	logic [7:0] req_func, req_qty, rsp_func;
	logic [15:0] req_start, rsp_data;
	logic [4:0] alerts = 5'h00;
	logic cnt_update = 1'b0;
	logic [31:0] ch [4] = '{32'h3F800000, 32'h40000000, 32'h40400000,
		32'h42C50A11};
	logic [63:0] unit_str = 64'h636E2F6D33000000;
	logic [3:0] ch_present = 4'hF;
	logic [31:0] alo = 32'h00000000;
	logic [31:0] ahi = 32'h49742400;
	logic [15:0] aroute = 16'h0002;
	logic [31:0] alimit = 32'h48F42400;
	logic [31:0] amroute = 32'h00000001;
	logic alarm_en = 1'b0;
	logic relay_closed;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	always #50 clk = ~clk;
	pcmr_regs pcmr_regs_i (.clk(clk), .srst(srst), .req_valid(req_valid),
		.req_func(req_func), .req_start(req_start), .req_qty(req_qty),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
		.rsp_func(rsp_func), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
		.rsp_last(rsp_last), .laser_alert(alerts[0]),
		.flow_alert(alerts[1]), .overflow_alert(alerts[2]),
		.service_alert(alerts[3]), .thresh_alert(alerts[4]),
		.cnt_update(cnt_update), .counts({ch[3], ch[2], ch[1], ch[0]}),
		.unit_str(unit_str), .ch_present(ch_present), .alo(alo), .ahi(ahi),
		.aroute(aroute), .alimit(alimit), .amroute(amroute),
		.alarm_en(alarm_en), .relay_closed(relay_closed));
	pcmr_mstr pcmr_mstr_i (.clk(clk), .req_valid(req_valid),
		.req_func(req_func), .req_start(req_start), .req_qty(req_qty),
		.req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
		.rsp_func(rsp_func), .rsp_data(rsp_data), .rsp_exc(rsp_exc),
		.rsp_last(rsp_last));
	task automatic print_verdict();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// whole run is a few hundred cycles; ceiling well above that
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] q);
		pcmr_mstr_i.read(FC_READ_HOLD, a, q);
	endtask
	task automatic pulse();
		@(negedge clk);
		cnt_update = 1'b1;
		@(negedge clk);
		cnt_update = 1'b0;
	endtask
	task automatic t_reset();
		chk(relay_closed, 1'b1);
		chk(req_ready, 1'b1);
		rd(ADDR_STATUS, 8'h02);
		chk(pcmr_mstr_i.w32(0), 32'h00000000);
	endtask
	task automatic t_map();
		pcmr_mstr_i.stall = 2;
		rd(ADDR_CH1, 8'h08);
		pcmr_mstr_i.stall = 0;
		for (int i = 0; i < 4; i++) begin
			chk(pcmr_mstr_i.w32(2 * i), ch[i]);
		end
		chk(pcmr_mstr_i.words[0], ch[0][15:0]);
		rd(ADDR_ALO, 8'h04);
		chk(pcmr_mstr_i.w32(0), alo);
		chk(pcmr_mstr_i.w32(2), ahi);
		rd(ADDR_AROUTE, 8'h01);
		chk(pcmr_mstr_i.words[0], aroute);
		chk(pcmr_mstr_i.last_func, FC_READ_HOLD);
		rd(ADDR_ALIMIT, 8'h04);
		chk(pcmr_mstr_i.w32(0), alimit);
		chk(pcmr_mstr_i.w32(2), amroute);
	endtask
	task automatic t_unit();
		rd(ADDR_UNIT, 8'h04);
		for (int i = 0; i < 4; i++) begin
			chk(pcmr_mstr_i.words[i], unit_str[63 - 16 * i -: 16]);
		end
		// monitored channel two removed from the model
		ch_present = 4'hD;
		pulse();
		rd(ADDR_UNIT, 8'h04);
		for (int i = 0; i < 4; i++) begin
			chk(pcmr_mstr_i.words[i], 16'h0000);
		end
		ch_present = 4'hF;
	endtask
	task automatic t_status();
		for (int b = 0; b < 5; b++) begin
			alerts = 5'h01 << b;
			pulse();
			rd(ADDR_STATUS, 8'h02);
			chk(pcmr_mstr_i.w32(0), 32'h00000001 << b);
		end
		alerts = 5'h00;
	endtask
	task automatic t_alarm();
		alarm_en = 1'b1;
		ch[1] = alimit - 32'h00000001;
		ch[0] = alimit + 32'h00000010;
		pulse();
		chk(relay_closed, 1'b1);
		ch[1] = alimit;
		@(negedge clk);
		chk(relay_closed, 1'b1);
		pulse();
		chk(relay_closed, 1'b0);
		rd(ADDR_STATUS, 8'h02);
		chk(pcmr_mstr_i.w32(0), 32'h00000020);
		alarm_en = 1'b0;
		pulse();
		chk(relay_closed, 1'b1);
		rd(ADDR_STATUS, 8'h02);
		chk(pcmr_mstr_i.w32(0), 32'h00000000);
	endtask
	task automatic t_route();
		// alarm moved to channel four, fresh configuration copies
		amroute = 32'h00000003;
		alimit = 32'h47C35000;
		alo = 32'h3F000000;
		ahi = 32'h4B189680;
		aroute = 16'h0003;
		unit_str = 64'h636E2F6C00000000;
		ch[2] = 32'h41200000;
		ch[3] = alimit - 32'h00000001;
		ch[1] = alimit + 32'h00000001;
		alarm_en = 1'b1;
		pulse();
		chk(relay_closed, 1'b1);
		ch[3] = alimit;
		pulse();
		chk(relay_closed, 1'b0);
		rd(ADDR_CH3, 8'h04);
		chk(pcmr_mstr_i.w32(0), ch[2]);
		chk(pcmr_mstr_i.w32(2), ch[3]);
		rd(ADDR_ALO, 8'h04);
		chk(pcmr_mstr_i.w32(0), alo);
		chk(pcmr_mstr_i.w32(2), ahi);
		rd(ADDR_ALIMIT, 8'h04);
		chk(pcmr_mstr_i.w32(0), alimit);
		chk(pcmr_mstr_i.w32(2), amroute);
		// routing is a single word; the address after it is a hole
		rd(ADDR_AROUTE, 8'h02);
		chk(pcmr_mstr_i.words[0], aroute);
		chk(pcmr_mstr_i.words[1][7:0], EXC_BAD_ADDR);
		chk(pcmr_mstr_i.last_exc, 1'b1);
		rd(ADDR_UNIT, 8'h01);
		chk(pcmr_mstr_i.words[0], unit_str[63:48]);
		ch_present = 4'h7;
		rd(ADDR_UNIT, 8'h01);
		chk(pcmr_mstr_i.words[0], 16'h0000);
		ch_present = 4'hF;
		alarm_en = 1'b0;
		pulse();
		chk(relay_closed, 1'b1);
	endtask
	task automatic t_exc();
		// unsupported function code on purpose
		pcmr_mstr_i.read(8'h04, ADDR_CH1, 8'h02);
		chk(pcmr_mstr_i.last_exc, 1'b1);
		chk(pcmr_mstr_i.last_func, FC_EXC_FLAG | 8'h04);
		chk(pcmr_mstr_i.words[0][7:0], EXC_BAD_FUNC);
		rd(ADDR_CH4, 8'h03);
		chk(pcmr_mstr_i.w32(0), ch[3]);
		chk(pcmr_mstr_i.words.size(), 32'h00000003);
		chk(pcmr_mstr_i.words[2][7:0], EXC_BAD_ADDR);
		chk(pcmr_mstr_i.last_exc, 1'b1);
		// zero quantity is refused with a single exception word
		rd(ADDR_STATUS, 8'h00);
		chk(pcmr_mstr_i.words.size(), 32'h00000001);
		chk(pcmr_mstr_i.last_exc, 1'b1);
		chk(pcmr_mstr_i.last_func, FC_EXC_FLAG | FC_READ_HOLD);
		chk(pcmr_mstr_i.words[0][7:0], EXC_BAD_ADDR);
	endtask
	initial begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		t_reset();
		t_map();
		t_unit();
		t_status();
		t_alarm();
		t_route();
		t_exc();
		print_verdict();
	end
endmodule
